// *** hw/cacc_pkg.sv ***
// constants, register map and carrier types for the counter array block
package cacc_pkg;

  // ==========================================================
  // geometry
  localparam int NUM_UNITS = 5;
  localparam int WDOG_UNIT = 4;

  typedef logic [7:0]  cacc_byte_t;
  typedef logic [15:0] cacc_word_t;

  // ==========================================================
  // register addresses on the special-function-register bus
  localparam cacc_byte_t ADDR_CTRL   = 8'hd8;
  localparam cacc_byte_t ADDR_CNT_LO = 8'hf9;
  localparam cacc_byte_t ADDR_CNT_HI = 8'hfa;
  localparam cacc_byte_t ADDR_MODE [NUM_UNITS] = '{8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde};
  localparam cacc_byte_t ADDR_VAL_LO [NUM_UNITS] = '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd};
  localparam cacc_byte_t ADDR_VAL_HI [NUM_UNITS] = '{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe};

  // ==========================================================
  // field positions of the control register
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int CTRL_FLAG_LSB = 0;

  // ==========================================================
  // reset values and limits
  localparam cacc_word_t CNT_RESET  = 16'h0000;
  localparam cacc_word_t CNT_MAX    = 16'hffff;
  localparam cacc_word_t CNT_STEP   = 16'h0001;
  localparam cacc_byte_t BYTE_ZERO  = 8'h00;
  localparam cacc_byte_t BYTE_MAX   = 8'hff;

  // ==========================================================
  // mode register layout, bit 7 down to bit 0
  typedef struct packed {
    logic wide;   // wide_modulation_select
    logic comp;   // comparator_enable
    logic rise;   // rising_capture_enable
    logic fall;   // falling_capture_enable
    logic mat;    // match_flag_enable
    logic tog;    // toggle_enable
    logic pwm;    // modulation_enable
    logic irq;    // module_irq_mask
  } cacc_mode_t;

  localparam cacc_mode_t MODE_RESET = '0;

  // one bus request: address, strobes and write data
  typedef struct packed {
    cacc_byte_t addr;
    logic       wr;
    logic       rd;
    cacc_byte_t wdata;
  } cacc_sfr_req_t;

endpackage

// *** hw/cacc_unit.sv ***
// one capture/compare module: edge capture, match, toggle, modulation, frequency output
module cacc_unit (
  // clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               reset_i,
  // configuration and shared state
  input  wire cacc_pkg::cacc_mode_t mode_i,
  input  wire cacc_pkg::cacc_word_t value_i,
  input  wire cacc_pkg::cacc_word_t count_i,
  input  wire logic               tick_i,
  // synchronised pin samples
  input  wire logic               pin_now_i,
  input  wire logic               pin_prev_i,
  // events to the register file
  output logic                    capture_o,
  output logic                    event_o,
  output logic                    freq_hit_o,
  // pin drive
  output logic                    pin_o,
  output logic                    pin_oe_o
);
  import cacc_pkg::*;

  logic cmp_hit;
  logic lo_hit;
  logic freq_mode;
  logic pin_reg;
  logic pin_next;
  logic oe_reg;
  logic oe_next;

  // ==========================================================
  // event decode
  always_comb begin
    cmp_hit    = mode_i.comp && tick_i && (count_i == value_i);
    lo_hit     = mode_i.comp && tick_i && (count_i[7:0] == value_i[7:0]);
    capture_o  = (mode_i.rise && pin_now_i && !pin_prev_i)
              || (mode_i.fall && !pin_now_i && pin_prev_i);
    freq_mode  = mode_i.tog && mode_i.pwm;
    freq_hit_o = freq_mode && lo_hit;
    event_o    = capture_o || (mode_i.mat && cmp_hit);
  end

  // ==========================================================
  // pin waveform
  always_comb begin
    pin_next = pin_reg;
    oe_next  = mode_i.tog || mode_i.pwm;
    if (freq_mode) begin
      pin_next = pin_reg ^ lo_hit;
    end else if (mode_i.pwm) begin
      if (mode_i.wide) begin
        pin_next = (count_i >= value_i);
      end else begin
        pin_next = (count_i[7:0] >= value_i[7:0]);
      end
    end else if (mode_i.tog && cmp_hit) begin
      pin_next = !pin_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else begin
      pin_reg <= pin_next;
      oe_reg  <= oe_next;
    end
  end

  assign pin_o    = pin_reg;
  assign pin_oe_o = oe_reg;

  // ==========================================================
  // checks
  chk_toggle_match: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (mode_i.tog && !mode_i.pwm && cmp_hit) |=> (pin_o != $past(pin_o)))
    else $error("toggle match did not invert the pin");

  chk_edge_select: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    capture_o |-> ((mode_i.rise && pin_now_i) || (mode_i.fall && !pin_now_i)))
    else $error("capture on a disabled edge");

endmodule

// *** hw/cacc_top.sv ***
// counter array with five capture/compare modules behind the sfr bus
//
// Summary of operation
// - five identical modules 0..4, each with mode and 16-bit value, one shared counter
// - mode bit 7 picks 8-bit or 16-bit modulation when modulation is on
// - mode bit 6 enables the comparator of the module
// - mode bit 5 enables capture on rising pin edges
// - mode bit 4 enables capture on falling pin edges
// - mode bit 3: counter equal to value sets the module flag
// - mode bit 2: counter equal to value inverts the module pin
// - toggle and modulation both set select frequency output mode
// - mode bit 1 drives a modulated waveform on the module pin
// - mode bit 0 lets a set module flag raise an interrupt request
// - shared counter read and written as low and high byte registers
// - each module value read and written as low and high byte registers
// - flag set on match or capture stays set until software clears it
// - counter wrap from all ones to zero sets a sticky overflow flag
// - with watchdog enabled, module four serves as the watchdog
module cacc_top (
  // clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_i,
  // special-function-register bus
  input  wire cacc_pkg::cacc_sfr_req_t sfr_req_i,
  output logic [7:0]                   sfr_rdata_o,
  // module pins
  input  wire logic [4:0]              module_pin_i,
  output logic [4:0]                   module_pin_o,
  output logic [4:0]                   module_pin_oe_o,
  // watchdog and interrupt
  input  wire logic                    watchdog_enable_i,
  output logic                         irq_o,
  output logic                         watchdog_reset_o
);
  import cacc_pkg::*;

  // ==========================================================
  // state
  cacc_word_t           cnt_reg;
  cacc_word_t           cnt_next;
  logic                 run_reg;
  logic                 run_next;
  logic                 ovf_reg;
  logic                 ovf_next;
  logic [NUM_UNITS-1:0] flag_reg;
  logic [NUM_UNITS-1:0] flag_next;
  cacc_mode_t           mode_reg [NUM_UNITS];
  cacc_mode_t           mode_next [NUM_UNITS];
  cacc_word_t           val_reg [NUM_UNITS];
  cacc_word_t           val_next [NUM_UNITS];
  cacc_byte_t           rdata_reg;
  cacc_byte_t           rdata_next;
  logic                 irq_reg;
  logic                 irq_next;
  logic                 wdt_reg;
  logic                 wdt_next;
  logic [NUM_UNITS-1:0] pin_s1_reg;
  logic [NUM_UNITS-1:0] pin_s2_reg;
  logic [NUM_UNITS-1:0] pin_s3_reg;

  // ==========================================================
  // per-module wiring
  logic                 tick;
  logic                 cnt_wr;
  logic                 ctrl_wr;
  logic                 wdog_on;
  logic [NUM_UNITS-1:0] cap;
  logic [NUM_UNITS-1:0] evt;
  logic [NUM_UNITS-1:0] freq_hit;
  logic [NUM_UNITS-1:0] irq_cause;
  cacc_mode_t           unit_mode [NUM_UNITS];

  // true when the current request writes the given address
  function automatic logic wr_at(input cacc_sfr_req_t req, input cacc_byte_t addr);
    return req.wr && (req.addr == addr);
  endfunction

  // read multiplexer over the whole map; unmapped addresses read zero
  function automatic cacc_byte_t read_mux(input cacc_byte_t addr);
    cacc_byte_t data;
    data = BYTE_ZERO;
    if (addr == ADDR_CTRL) begin
      data[CTRL_OVF_BIT] = ovf_reg;
      data[CTRL_RUN_BIT] = run_reg;
      data[CTRL_FLAG_LSB +: NUM_UNITS] = flag_reg;
    end
    if (addr == ADDR_CNT_LO) begin
      data = cnt_reg[7:0];
    end
    if (addr == ADDR_CNT_HI) begin
      data = cnt_reg[15:8];
    end
    for (int i = 0; i < NUM_UNITS; i++) begin
      if (addr == ADDR_MODE[i]) begin
        data = mode_reg[i];
      end
      if (addr == ADDR_VAL_LO[i]) begin
        data = val_reg[i][7:0];
      end
      if (addr == ADDR_VAL_HI[i]) begin
        data = val_reg[i][15:8];
      end
    end
    return data;
  endfunction

  // ==========================================================
  // pin synchronisers: first stage feeds only the second
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= module_pin_i;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // ==========================================================
  // capture/compare modules
  always_comb begin
    wdog_on = watchdog_enable_i;
    for (int i = 0; i < NUM_UNITS; i++) begin
      unit_mode[i] = mode_reg[i];
    end
    if (wdog_on) begin
      unit_mode[WDOG_UNIT] = MODE_RESET;
    end
  end

  for (genvar g = 0; g < NUM_UNITS; g++) begin : gen_unit
    cacc_unit u_unit (
      .ref_clk_i  (ref_clk_i),
      .reset_i    (reset_i),
      .mode_i     (unit_mode[g]),
      .value_i    (val_reg[g]),
      .count_i    (cnt_reg),
      .tick_i     (tick),
      .pin_now_i  (pin_s2_reg[g]),
      .pin_prev_i (pin_s3_reg[g]),
      .capture_o  (cap[g]),
      .event_o    (evt[g]),
      .freq_hit_o (freq_hit[g]),
      .pin_o      (module_pin_o[g]),
      .pin_oe_o   (module_pin_oe_o[g])
    );
  end

  // ==========================================================
  // shared counter and control register
  always_comb begin
    ctrl_wr  = wr_at(sfr_req_i, ADDR_CTRL);
    cnt_wr   = wr_at(sfr_req_i, ADDR_CNT_LO) || wr_at(sfr_req_i, ADDR_CNT_HI);
    tick     = run_reg && !cnt_wr;
    cnt_next = cnt_reg;
    run_next = run_reg;
    ovf_next = ovf_reg;
    if (wr_at(sfr_req_i, ADDR_CNT_LO)) begin
      cnt_next[7:0] = sfr_req_i.wdata;
    end
    if (wr_at(sfr_req_i, ADDR_CNT_HI)) begin
      cnt_next[15:8] = sfr_req_i.wdata;
    end
    if (tick) begin
      cnt_next = cacc_word_t'(cnt_reg + CNT_STEP);
    end
    if (ctrl_wr) begin
      run_next = sfr_req_i.wdata[CTRL_RUN_BIT];
      ovf_next = sfr_req_i.wdata[CTRL_OVF_BIT];
    end
    if (tick && (cnt_reg == CNT_MAX)) begin
      ovf_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cnt_reg <= CNT_RESET;
      run_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      ovf_reg <= ovf_next;
    end
  end

  // ==========================================================
  // module flags, modes and values
  always_comb begin
    flag_next = flag_reg;
    if (ctrl_wr) begin
      flag_next = sfr_req_i.wdata[CTRL_FLAG_LSB +: NUM_UNITS];
    end
    flag_next = flag_next | evt;
    for (int i = 0; i < NUM_UNITS; i++) begin
      mode_next[i] = mode_reg[i];
      val_next[i]  = val_reg[i];
      if (wr_at(sfr_req_i, ADDR_MODE[i])) begin
        mode_next[i] = sfr_req_i.wdata;
      end
      if (wr_at(sfr_req_i, ADDR_VAL_LO[i])) begin
        val_next[i][7:0] = sfr_req_i.wdata;
      end
      if (wr_at(sfr_req_i, ADDR_VAL_HI[i])) begin
        val_next[i][15:8] = sfr_req_i.wdata;
      end
      if (freq_hit[i]) begin
        val_next[i][7:0] = cacc_byte_t'(val_reg[i][7:0] + val_reg[i][15:8]);
      end
      if (cap[i]) begin
        val_next[i] = cnt_reg;
      end
    end
    // watchdog reload: high byte becomes counter high plus offset
    if (wdog_on && wr_at(sfr_req_i, ADDR_VAL_HI[WDOG_UNIT])) begin
      val_next[WDOG_UNIT][15:8] =
        cacc_byte_t'(cnt_reg[15:8] + val_reg[WDOG_UNIT][7:0]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      flag_reg <= '0;
      for (int i = 0; i < NUM_UNITS; i++) begin
        mode_reg[i] <= MODE_RESET;
        val_reg[i]  <= CNT_RESET;
      end
    end else begin
      flag_reg <= flag_next;
      for (int i = 0; i < NUM_UNITS; i++) begin
        mode_reg[i] <= mode_next[i];
        val_reg[i]  <= val_next[i];
      end
    end
  end

  // ==========================================================
  // interrupt request, watchdog reset and read data
  always_comb begin
    for (int i = 0; i < NUM_UNITS; i++) begin
      irq_cause[i] = flag_reg[i] && mode_reg[i].irq;
    end
    irq_next = |irq_cause;
    wdt_next = wdog_on
            && ((tick && (cnt_reg[7:0] == BYTE_MAX)
                 && (cnt_reg[15:8] == val_reg[WDOG_UNIT][15:8]))
                || (ctrl_wr && sfr_req_i.wdata[CTRL_FLAG_LSB + WDOG_UNIT]));
    rdata_next = rdata_reg;
    if (sfr_req_i.rd) begin
      rdata_next = read_mux(sfr_req_i.addr);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_reg   <= 1'b0;
      wdt_reg   <= 1'b0;
      rdata_reg <= BYTE_ZERO;
    end else begin
      irq_reg   <= irq_next;
      wdt_reg   <= wdt_next;
      rdata_reg <= rdata_next;
    end
  end

  assign irq_o            = irq_reg;
  assign watchdog_reset_o = wdt_reg;
  assign sfr_rdata_o      = rdata_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  chk_ovf_wrap: assert property (
    (tick && cnt_reg == CNT_MAX) |=> (ovf_reg && cnt_reg == CNT_RESET))
    else $error("counter wrap did not set overflow flag");

  chk_ovf_sticky: assert property (
    (ovf_reg && !ctrl_wr) |=> ovf_reg)
    else $error("overflow flag dropped without software clear");

  chk_flag_sticky: assert property (
    (flag_reg[1] && !ctrl_wr) |=> flag_reg[1])
    else $error("module flag dropped without software clear");

  chk_capture_copy: assert property (
    cap[2] |=> (flag_reg[2] && val_reg[2] == $past(cnt_reg)))
    else $error("capture did not copy counter and set flag");

  chk_match_flag: assert property (
    (tick && mode_reg[0].comp && mode_reg[0].mat && cnt_reg == val_reg[0])
      |=> flag_reg[0])
    else $error("match did not set module flag");

  chk_no_comp: assert property (
    (!mode_reg[3].comp && !mode_reg[3].rise && !mode_reg[3].fall) |-> !evt[3])
    else $error("event raised with comparator and capture off");

  chk_irq_raise: assert property (
    (flag_reg[0] && mode_reg[0].irq) |=> irq_o)
    else $error("masked-in flag did not raise the request");

  chk_irq_quiet: assert property (
    (irq_cause == '0) |=> !irq_o)
    else $error("request raised with no enabled flag");

  chk_cnt_byte_wr: assert property (
    wr_at(sfr_req_i, ADDR_CNT_LO) |=> (cnt_reg[7:0] == $past(sfr_req_i.wdata)))
    else $error("counter low byte write lost");

  chk_cnt_hold: assert property (
    (!run_reg && !cnt_wr) |=> $stable(cnt_reg))
    else $error("stopped counter moved");

  chk_val_rdback: assert property (
    (sfr_req_i.rd && sfr_req_i.addr == ADDR_VAL_HI[1]) |=> (sfr_rdata_o == $past(val_reg[1][15:8])))
    else $error("value high byte read mismatch");

  chk_wdog_mask: assert property (
    watchdog_enable_i |-> (unit_mode[WDOG_UNIT] == MODE_RESET))
    else $error("module four active while watchdog enabled");

  // software may force the watchdog reset through the module four flag bit
  chk_wdog_force: assert property (
    (wdog_on && ctrl_wr && sfr_req_i.wdata[CTRL_FLAG_LSB + WDOG_UNIT]) |=> watchdog_reset_o)
    else $error("forced watchdog reset did not pulse");

  // reset itself is the antecedent here, so this check must not be disabled by it
  chk_reset_zero: assert property (@(posedge ref_clk_i) disable iff (1'b0)
    reset_i |=> (cnt_reg == CNT_RESET && mode_reg[0] == MODE_RESET && val_reg[4] == CNT_RESET))
    else $error("registers not zero after reset");

  cov_capture: cover property (cap[2] ##1 flag_reg[2]);
  cov_wrap: cover property (tick && cnt_reg == CNT_MAX);
  cov_freq: cover property (freq_hit[1]);
  cov_wdog: cover property (watchdog_reset_o);

endmodule

// *** verification/cacc_top_test.sv ***
// self-checking testbench for the counter array top level
module cacc_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import cacc_pkg::*;

  // ==========================================================
  // design connections
  logic          ref_clk_i;
  logic          reset_i;
  cacc_sfr_req_t sfr_req_i;
  logic [7:0]    sfr_rdata_o;
  logic [4:0]    module_pin_i;
  logic [4:0]    module_pin_o;
  logic [4:0]    module_pin_oe_o;
  logic          watchdog_enable_i;
  logic          irq_o;
  logic          watchdog_reset_o;
  int            fail_count;
  int            checked;
  cacc_byte_t    row_addr [19];
  cacc_byte_t    row_data [19];
  cacc_byte_t    row_exp [19];
  cacc_byte_t    rd;
  int            hits;
  logic          last_pin;

  cacc_top u_dut (
    .ref_clk_i         (ref_clk_i),
    .reset_i           (reset_i),
    .sfr_req_i         (sfr_req_i),
    .sfr_rdata_o       (sfr_rdata_o),
    .module_pin_i      (module_pin_i),
    .module_pin_o      (module_pin_o),
    .module_pin_oe_o   (module_pin_oe_o),
    .watchdog_enable_i (watchdog_enable_i),
    .irq_o             (irq_o),
    .watchdog_reset_o  (watchdog_reset_o)
  );

  // ==========================================================
  // clock at 100 MHz
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================================
  // shared tasks
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // inputs change one step after the rising edge
  task automatic do_reset();
    @(posedge ref_clk_i);
    #1 reset_i = 1'b1;
    tick(4);
    reset_i = 1'b0;
  endtask

  task automatic sfr_write(input cacc_byte_t a, input cacc_byte_t d);
    @(posedge ref_clk_i);
    #1 sfr_req_i = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    tick(1);
    sfr_req_i.wr = 1'b0;
  endtask

  task automatic sfr_read(input cacc_byte_t a, output cacc_byte_t d);
    @(posedge ref_clk_i);
    #1 sfr_req_i = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: BYTE_ZERO};
    tick(1);
    sfr_req_i.rd = 1'b0;
    d = sfr_rdata_o;
  endtask

  task automatic read_check(input cacc_byte_t a, input cacc_byte_t mask, input cacc_byte_t exp,
                            input string what);
    cacc_byte_t v;
    sfr_read(a, v);
    check8(v & mask, exp, what);
  endtask

  // bounded wait on irq (sel 0) or watchdog pulse (sel 1)
  task automatic wait_sig(input int sel, input int limit);
    int n;
    n = 0;
    while (((sel == 0) ? irq_o : watchdog_reset_o) !== 1'b1) begin
      n++;
      if (n > limit) begin
        check8(8'h00, 8'h01, "wait bound used up");
        conclude();
      end
      tick(1);
    end
  endtask

  // count cycles with a module pin high over a window
  task automatic count_high(input int unit, input int cycles, output int high);
    high = 0;
    repeat (cycles) begin
      tick(1);
      high += int'(module_pin_o[unit]);
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    reset_i = 1'b1;
    sfr_req_i = '0;
    module_pin_i = 5'h00;
    watchdog_enable_i = 1'b0;
    fail_count = 0;
    checked = 0;
    tick(4);
    reset_i = 1'b0;
    // table rows: every mapped byte except the control register, counter held stopped, plus two unmapped places
    for (int i = 0; i < NUM_UNITS; i++) begin
      row_addr[i] = ADDR_MODE[i];
      row_addr[i + 5] = ADDR_VAL_LO[i];
      row_addr[i + 10] = ADDR_VAL_HI[i];
    end
    row_addr[15] = ADDR_CNT_LO;
    row_addr[16] = ADDR_CNT_HI;
    row_addr[17] = 8'hd9;
    row_addr[18] = 8'hf8;
    for (int i = 0; i < 19; i++) begin
      row_data[i] = row_addr[i] ^ 8'h5a;
      row_exp[i] = (i > 16) ? BYTE_ZERO : row_data[i];
    end
    for (int i = 0; i < 19; i++) begin
      read_check(row_addr[i], BYTE_MAX, BYTE_ZERO, "reset value");
    end
    for (int i = 0; i < 19; i++) sfr_write(row_addr[i], row_data[i]);
    for (int i = 0; i < 19; i++) begin
      read_check(row_addr[i], BYTE_MAX, row_exp[i], "readback");
    end
    do_reset();
    read_check(ADDR_MODE[3], BYTE_MAX, BYTE_ZERO, "mode after reset");

    // match with the interrupt masked, then unmasked
    sfr_write(ADDR_VAL_LO[0], 8'h10);
    sfr_write(ADDR_MODE[0], 8'h48);
    sfr_write(ADDR_VAL_LO[3], 8'h20);
    sfr_write(ADDR_MODE[3], 8'h0c);
    sfr_write(ADDR_VAL_LO[1], 8'h20);
    sfr_write(ADDR_MODE[1], 8'h44);
    sfr_write(ADDR_CTRL, 8'h40);
    tick(60);
    check8({7'h00, irq_o}, 8'h00, "irq while masked");
    check8({6'h00, module_pin_oe_o[1], module_pin_o[1]}, 8'h03, "toggled pin");
    check8({7'h00, module_pin_o[3]}, 8'h00, "no toggle with comparator off");
    read_check(ADDR_CTRL, 8'h1f, 8'h01, "match flags");
    sfr_write(ADDR_MODE[0], 8'h49);
    wait_sig(0, 3);
    tick(300);
    read_check(ADDR_CTRL, 8'h01, 8'h01, "flag sticky");
    sfr_write(ADDR_CTRL, 8'h00);
    tick(2);
    read_check(ADDR_CTRL, 8'h1f, 8'h00, "flags cleared");
    check8({7'h00, irq_o}, 8'h00, "irq cleared");

    // capture with the counter stopped: rising on unit 2, falling only on unit 3
    do_reset();
    sfr_write(ADDR_CNT_LO, 8'h34);
    sfr_write(ADDR_CNT_HI, 8'h12);
    sfr_write(ADDR_MODE[2], 8'h20);
    sfr_write(ADDR_MODE[3], 8'h10);
    module_pin_i = 5'h0c;
    tick(6);
    read_check(ADDR_CTRL, 8'h1f, 8'h04, "rising capture flag");
    read_check(ADDR_VAL_LO[2], BYTE_MAX, 8'h34, "captured low");
    read_check(ADDR_VAL_HI[2], BYTE_MAX, 8'h12, "captured high");
    read_check(ADDR_VAL_LO[3], BYTE_MAX, BYTE_ZERO, "no capture on rise");
    module_pin_i = 5'h00;
    tick(6);
    read_check(ADDR_CTRL, 8'h1f, 8'h0c, "falling capture flag");
    read_check(ADDR_VAL_HI[3], BYTE_MAX, 8'h12, "falling captured high");

    // overflow from all ones to zero
    sfr_write(ADDR_CNT_HI, 8'hff);
    sfr_write(ADDR_CNT_LO, 8'hf0);
    sfr_write(ADDR_CTRL, 8'h40);
    tick(30);
    read_check(ADDR_CTRL, 8'h80, 8'h80, "overflow flag");
    tick(20);
    read_check(ADDR_CTRL, 8'h80, 8'h80, "overflow sticky");

    // 8-bit modulation: half duty, then frequency output every 16 counts
    do_reset();
    sfr_write(ADDR_VAL_LO[0], 8'h80);
    sfr_write(ADDR_MODE[0], 8'h42);
    sfr_write(ADDR_VAL_HI[1], 8'h10);
    sfr_write(ADDR_MODE[1], 8'h46);
    sfr_write(ADDR_CTRL, 8'h40);
    tick(40);
    count_high(0, 256, hits);
    check8(hits[7:0], 8'h80, "8-bit duty");
    hits = 0;
    last_pin = module_pin_o[1];
    repeat (256) begin
      tick(1);
      hits += int'(module_pin_o[1] != last_pin);
      last_pin = module_pin_o[1];
    end
    check8(hits[7:0], 8'h10, "frequency toggles");

    // 16-bit modulation: quarter duty over the full count
    do_reset();
    sfr_write(ADDR_VAL_HI[0], 8'hc0);
    sfr_write(ADDR_MODE[0], 8'hc2);
    sfr_write(ADDR_CTRL, 8'h40);
    tick(10);
    count_high(0, 65536, hits);
    check8(hits[15:8], 8'h40, "16-bit duty");
    check8(hits[7:0], 8'h00, "16-bit duty low");

    // watchdog on unit 4 fires once the low byte rolls with high bytes equal
    do_reset();
    watchdog_enable_i = 1'b1;
    sfr_write(ADDR_CTRL, 8'h40);
    wait_sig(1, 300);
    check8({7'h00, watchdog_reset_o}, 8'h01, "watchdog pulse");
    tick(1);
    check8({7'h00, watchdog_reset_o}, 8'h00, "watchdog pulse width");
    // forced reset: run bit kept, module four flag written as one
    sfr_write(ADDR_CTRL, 8'h50);
    wait_sig(1, 2);
    check8({7'h00, watchdog_reset_o}, 8'h01, "forced watchdog pulse");
    watchdog_enable_i = 1'b0;
    conclude();
  end
endmodule
